/* File: pkg/frs_defs.svh */
`ifndef FRS_DEFS_SVH
`define FRS_DEFS_SVH

// result status one bit positions
`define FRS_RS1_PAST_LAST    7
`define FRS_RS1_UNUSED_HI    6
`define FRS_RS1_CRC_ANY      5
`define FRS_RS1_HOST_LATE    4
`define FRS_RS1_UNUSED_LO    3
`define FRS_RS1_NOT_FOUND    2
`define FRS_RS1_PROTECT      1
`define FRS_RS1_ID_SYNC      0

// result status two bit positions
`define FRS_RS2_UNUSED       7
`define FRS_RS2_DELETED      6
`define FRS_RS2_PAYLOAD_CRC  5
`define FRS_RS2_CYL_MISMATCH 4
`define FRS_RS2_SCAN_MATCH   3
`define FRS_RS2_SCAN_MISS    2
`define FRS_RS2_BAD_TRACK    1
`define FRS_RS2_DATA_SYNC    0

// result status three bit positions
`define FRS_RS3_ZERO         7
`define FRS_RS3_PROTECT_HI   6
`define FRS_RS3_DRIVE_OK     5
`define FRS_RS3_TRACK_ZERO   4
`define FRS_RS3_PROTECT_LO   3
`define FRS_RS3_SIDE         2
`define FRS_RS3_UNIT_HI      1
`define FRS_RS3_UNIT_LO      0

// constant values
`define FRS_BYTE_ZERO        8'h00
`define FRS_BAD_TRACK_CYL    8'hFF
`define FRS_SYNC_RESET       12'h000
`define FRS_SYNC_IDLE        12'hC00

`endif

/* File: pkg/frs_pkg.sv */
`default_nettype none

package frs_pkg;

    typedef logic [7:0] frs_byte_t;

    // source loaded into the data port for the host to read
    typedef enum logic [1:0] {
        FRS_SRC_CORE,
        FRS_SRC_RS1,
        FRS_SRC_RS2,
        FRS_SRC_RS3
    } frs_src_e;

endpackage : frs_pkg

`default_nettype wire

/* File: hdl/frs_port.sv */
// Contract
// RULE1 - past last sector sets rs1 bit 7
// RULE2 - rs1 bits 6 and 3 read zero
// RULE3 - any crc failure sets rs1 bit 5
// RULE4 - late host service sets rs1 bit 4
// RULE5 - sector not found sets rs1 bit 2
// RULE6 - write protect during write sets bit 1
// RULE7 - missing mark sets rs1 bit 0
// RULE8 - rs2 bit 7 reads zero
// RULE9 - deleted mark seen sets rs2 bit 6
// RULE10 - data field crc sets rs2 bit 5
// RULE11 - cylinder mismatch sets rs2 bit 4
// RULE12 - mismatch with medium FF sets bit 1
// RULE13 - scan equal sets rs2 bit 3
// RULE14 - scan without match sets rs2 bit 2
// RULE15 - missing data mark sets rs2 bit 0
// RULE16 - rs3 bits 6 and 3 show protect
// RULE17 - rs3 bit 5 one, bit 7 zero
// RULE18 - rs3 bit 4 shows track zero
// RULE19 - rs3 bits 2..0 show side, unit
// RULE20 - eight-bit host data port
// RULE21 - select low fetch reads main status
// RULE22 - select high fetch reads data port
// RULE23 - select high store writes data port
// RULE24 - host never makes illegal strobe combinations
// RULE25 - host polls service and direction first
`default_nettype none
`include "frs_defs.svh"

module frs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,       // system clock
    input  wire logic             rst_n,     // async reset, active low
    input  wire logic [WIDTH-1:0] in_data,   // word to store
    input  wire logic             in_valid,  // store request
    output logic                  in_ready,  // room for a word
    output logic      [WIDTH-1:0] out_data,  // oldest word
    output logic                  out_valid, // word available
    input  wire logic             out_ready  // drain side takes word
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
            $error("frs_fifo depth must be a power of two of at least 2");
        end
        if (WIDTH < 1) begin : g_bad_width
            $error("frs_fifo width must be at least 1");
        end
    endgenerate

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_ptr_q;
    logic [AW:0]      rd_ptr_q;
    logic             push;
    logic             pop;

    assign in_ready  = (wr_ptr_q[AW-1:0] != rd_ptr_q[AW-1:0]) || (wr_ptr_q[AW] == rd_ptr_q[AW]);
    assign out_valid = (wr_ptr_q != rd_ptr_q);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_q[rd_ptr_q[AW-1:0]];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_ptr_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= '0;
        end else if (push) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_ptr_q <= '0;
        end else if (pop) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
        end
    end

endmodule : frs_fifo

module frs_port #(
    parameter int RX_DEPTH = 4
) (
    input  wire logic       clk,                  // 40 MHz system clock
    input  wire logic       rst_n,                // async reset, active low
    // host bus pins
    input  wire logic       port_select_line,     // low main status, high data
    input  wire logic       host_fetch_strobe_n,  // read strobe, active low
    input  wire logic       host_store_strobe_n,  // write strobe, active low
    input  wire logic [7:0] bus_data_in,          // bus level seen at the pins
    output logic      [7:0] bus_data_out,         // byte driven to the bus
    output logic            bus_data_oe,          // high while driving the bus
    // drive pins
    input  wire logic       write_protect,        // drive write protect level
    input  wire logic       track_zero,           // drive track zero level
    // from the command sequencer
    input  wire logic [7:0] main_status,          // main status byte
    input  wire logic       side_choice,          // side driven to the drive
    input  wire logic       unit_bit_hi,          // unit choice bit 1
    input  wire logic       unit_bit_lo,          // unit choice bit 0
    input  wire logic       result_clear,         // pulse: new command, clear flags
    input  wire logic       ev_past_last_sector,  // pulse: beyond last sector
    input  wire logic       ev_id_crc,            // pulse: id field crc failure
    input  wire logic       ev_payload_crc,       // pulse: data field crc failure
    input  wire logic       ev_host_late,         // pulse: host missed a transfer
    input  wire logic       ev_sector_absent,     // pulse: sector not found
    input  wire logic       ev_write_cmd,         // level: write or format running
    input  wire logic       ev_id_mark_absent,    // pulse: no id mark after two index
    input  wire logic       ev_data_mark_absent,  // pulse: no data or deleted mark
    input  wire logic       ev_deleted_seen,      // pulse: deleted mark met
    input  wire logic       ev_scan_match,        // pulse: scan equal satisfied
    input  wire logic       ev_scan_miss,         // pulse: no sector met scan
    input  wire logic       id_check,             // pulse: compare cylinders now
    input  wire logic [7:0] medium_cylinder,      // cylinder read from medium
    input  wire logic [7:0] id_compare_buffer,    // expected cylinder
    // byte stream to the host
    input  wire logic [7:0] tx_data,              // byte for the data port
    input  wire logic [1:0] tx_source,            // frs_pkg::frs_src_e code
    input  wire logic       tx_valid,             // load request
    output logic            tx_ready,             // data port empty
    // byte stream from the host
    output logic      [7:0] rx_data,              // oldest host byte
    output logic            rx_valid,             // host byte available
    input  wire logic       rx_ready,             // sequencer takes host byte
    output logic            rx_space,             // buffer can take a host byte
    output logic            rx_overflow,          // pulse: host byte dropped
    // result registers
    output logic      [7:0] result_status_one,    // flags byte one
    output logic      [7:0] result_status_two,    // flags byte two
    output logic      [7:0] result_status_three   // drive state byte
);

    // pin synchronisers: {select, fetch_n, store_n, wp, tz, data}
    logic [12:0] meta_q;
    logic [12:0] sync_q;
    logic [12:0] pins;

    assign pins = {port_select_line, host_fetch_strobe_n, host_store_strobe_n,
                   write_protect, track_zero, bus_data_in};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= {1'b0, `FRS_SYNC_IDLE};
            sync_q <= {1'b0, `FRS_SYNC_IDLE};
        end else begin
            meta_q <= pins;
            sync_q <= meta_q;
        end
    end

    logic       sel_s;
    logic       fetch_s;
    logic       store_s;
    logic       wp_s;
    logic       tz_s;
    logic [7:0] data_s;

    assign sel_s   = sync_q[12];
    assign fetch_s = !sync_q[11];
    assign store_s = !sync_q[10];
    assign wp_s    = sync_q[9];
    assign tz_s    = sync_q[8];
    assign data_s  = sync_q[7:0];

    // strobe decode; other combinations are ignored
    logic rd_status;
    logic rd_port;
    logic wr_port;

    assign rd_status = !sel_s && fetch_s && !store_s; // [RULE21] [RULE24]
    assign rd_port   = sel_s && fetch_s && !store_s;  // [RULE22]
    assign wr_port   = sel_s && store_s && !fetch_s;  // [RULE23] [RULE24]

    logic rd_port_q;
    logic wr_port_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_port_q <= 1'b0;
            wr_port_q <= 1'b0;
        end else begin
            rd_port_q <= rd_port;
            wr_port_q <= wr_port;
        end
    end

    logic rd_done;
    logic wr_done;

    assign rd_done = rd_port_q && !rd_port;
    assign wr_done = wr_port_q && !wr_port;

    // byte held while the store strobe is active, pushed at its end
    logic [7:0] wr_hold_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_hold_q <= `FRS_BYTE_ZERO;
        end else if (wr_port) begin
            wr_hold_q <= data_s; // [RULE23]
        end
    end

    logic rx_in_ready;

    frs_fifo #(
        .WIDTH (8),
        .DEPTH (RX_DEPTH)
    ) u_rx_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_data   (wr_hold_q),
        .in_valid  (wr_done),
        .in_ready  (rx_in_ready),
        .out_data  (rx_data),
        .out_valid (rx_valid),
        .out_ready (rx_ready)
    );

    assign rx_space = rx_in_ready;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_overflow <= 1'b0;
        end else begin
            rx_overflow <= wr_done && !rx_in_ready;
        end
    end

    // result status one, sticky until result_clear; set wins
    logic [7:0] rs1_q;
    logic [7:0] rs1_set;
    logic       cyl_differs;

    always_comb begin
        rs1_set                      = `FRS_BYTE_ZERO;
        rs1_set[`FRS_RS1_PAST_LAST]  = ev_past_last_sector;                      // [RULE1]
        rs1_set[`FRS_RS1_CRC_ANY]    = ev_id_crc || ev_payload_crc;              // [RULE3]
        rs1_set[`FRS_RS1_HOST_LATE]  = ev_host_late;                             // [RULE4]
        rs1_set[`FRS_RS1_NOT_FOUND]  = ev_sector_absent || cyl_differs;          // [RULE5] [RULE11]
        rs1_set[`FRS_RS1_PROTECT]    = ev_write_cmd && wp_s;                     // [RULE6]
        rs1_set[`FRS_RS1_ID_SYNC]    = ev_id_mark_absent || ev_data_mark_absent; // [RULE7]
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rs1_q <= `FRS_BYTE_ZERO;
        end else if (result_clear) begin
            rs1_q <= rs1_set;
        end else begin
            rs1_q <= rs1_q | rs1_set;
        end
    end

    // cylinder comparison against the expected value
    assign cyl_differs = id_check && (medium_cylinder != id_compare_buffer); // [RULE11]

    // result status two
    logic [7:0] rs2_q;
    logic [7:0] rs2_set;

    always_comb begin
        rs2_set                        = `FRS_BYTE_ZERO;
        rs2_set[`FRS_RS2_DELETED]      = ev_deleted_seen;                              // [RULE9]
        rs2_set[`FRS_RS2_PAYLOAD_CRC]  = ev_payload_crc;                               // [RULE10]
        rs2_set[`FRS_RS2_CYL_MISMATCH] = cyl_differs;                                  // [RULE11]
        rs2_set[`FRS_RS2_SCAN_MATCH]   = ev_scan_match;                                // [RULE13]
        rs2_set[`FRS_RS2_SCAN_MISS]    = ev_scan_miss;                                 // [RULE14]
        rs2_set[`FRS_RS2_BAD_TRACK]    = cyl_differs
                                         && (medium_cylinder == `FRS_BAD_TRACK_CYL);   // [RULE12]
        rs2_set[`FRS_RS2_DATA_SYNC]    = ev_data_mark_absent;                          // [RULE7] [RULE15]
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rs2_q <= `FRS_BYTE_ZERO;
        end else if (result_clear) begin
            rs2_q <= rs2_set;
        end else begin
            rs2_q <= rs2_q | rs2_set;
        end
    end

    // unused bits forced low whatever the flops hold
    always_comb begin
        result_status_one                     = rs1_q;
        result_status_one[`FRS_RS1_UNUSED_HI] = 1'b0; // [RULE2]
        result_status_one[`FRS_RS1_UNUSED_LO] = 1'b0; // [RULE2]
        result_status_two                     = rs2_q;
        result_status_two[`FRS_RS2_UNUSED]    = 1'b0; // [RULE8]
    end

    // result status three, live drive state
    logic [7:0] rs3_live;

    always_comb begin
        rs3_live                      = `FRS_BYTE_ZERO; // [RULE17]
        rs3_live[`FRS_RS3_PROTECT_HI] = wp_s;           // [RULE16]
        rs3_live[`FRS_RS3_DRIVE_OK]   = 1'b1;           // [RULE17]
        rs3_live[`FRS_RS3_TRACK_ZERO] = tz_s;           // [RULE18]
        rs3_live[`FRS_RS3_PROTECT_LO] = wp_s;           // [RULE16]
        rs3_live[`FRS_RS3_SIDE]       = side_choice;    // [RULE19]
        rs3_live[`FRS_RS3_UNIT_HI]    = unit_bit_hi;    // [RULE19]
        rs3_live[`FRS_RS3_UNIT_LO]    = unit_bit_lo;    // [RULE19]
    end

    logic [7:0] rs3_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rs3_q <= `FRS_BYTE_ZERO;
        end else begin
            rs3_q <= rs3_live;
        end
    end

    assign result_status_three = rs3_q;

    // host data port, read side
    logic [7:0] host_data_port_q;
    logic       port_full_q;
    logic [7:0] tx_pick;

    always_comb begin
        case (frs_pkg::frs_src_e'(tx_source))
            frs_pkg::FRS_SRC_RS1: tx_pick = result_status_one;
            frs_pkg::FRS_SRC_RS2: tx_pick = result_status_two;
            frs_pkg::FRS_SRC_RS3: tx_pick = rs3_live;
            default:              tx_pick = tx_data;
        endcase
    end

    assign tx_ready = !port_full_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            host_data_port_q <= `FRS_BYTE_ZERO;
        end else if (tx_valid && !port_full_q) begin
            host_data_port_q <= tx_pick; // [RULE20]
        end
    end

    // a finished host read empties the port
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_full_q <= 1'b0;
        end else if (tx_valid && !port_full_q) begin
            port_full_q <= 1'b1;
        end else if (rd_done) begin
            port_full_q <= 1'b0; // [RULE20]
        end
    end

    // bus drive
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_data_out <= `FRS_BYTE_ZERO;
        end else if (rd_status) begin
            bus_data_out <= main_status;      // [RULE21]
        end else begin
            bus_data_out <= host_data_port_q; // [RULE22]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_data_oe <= 1'b0;
        end else begin
            bus_data_oe <= rd_status || rd_port; // [RULE21] [RULE22]
        end
    end

endmodule : frs_port

`default_nettype wire

/* File: verif/frs_port_asserts.sv */
`default_nettype none
module frs_port_asserts (
    input wire logic       clk,                 // clock
    input wire logic       rst_n,               // reset, active low
    input wire logic       port_select_line,    // select pin
    input wire logic       host_fetch_strobe_n, // read strobe
    input wire logic       host_store_strobe_n, // write strobe
    input wire logic       bus_data_oe,         // bus drive
    input wire logic       write_protect,       // drive protect
    input wire logic       side_choice,         // side level
    input wire logic       unit_bit_hi,         // unit bit 1
    input wire logic       unit_bit_lo,         // unit bit 0
    input wire logic       ev_past_last_sector, // event
    input wire logic       ev_id_crc,           // event
    input wire logic       ev_data_mark_absent, // event
    input wire logic       ev_write_cmd,        // write running
    input wire logic       id_check,            // compare pulse
    input wire logic [7:0] medium_cylinder,     // medium cylinder
    input wire logic [7:0] id_compare_buffer,   // expected cylinder
    input wire logic [7:0] result_status_one,   // flags one
    input wire logic [7:0] result_status_two,   // flags two
    input wire logic [7:0] result_status_three  // drive state
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    rs1_unused_a: assert property (
        !result_status_one[6] && !result_status_one[3]) else $error("rs1 unused bit set");
    rs2_unused_a: assert property (
        !result_status_two[7]) else $error("rs2 unused bit set");
    rs3_const_a: assert property (
        $past(rst_n) |-> result_status_three[5] && !result_status_three[7])
        else $error("rs3 constant bits wrong");
    rs3_units_a: assert property (
        $past(rst_n) |-> result_status_three[2] == $past(side_choice)
        && result_status_three[1] == $past(unit_bit_hi)
        && result_status_three[0] == $past(unit_bit_lo)) else $error("rs3 unit bits wrong");
    past_last_a: assert property (
        ev_past_last_sector |=> result_status_one[7]) else $error("past last not set");
    crc_any_a: assert property (
        ev_id_crc |=> result_status_one[5]) else $error("crc flag not set");
    data_mark_a: assert property (
        ev_data_mark_absent |=> result_status_one[0] && result_status_two[0])
        else $error("mark flags not set");
    cyl_mismatch_a: assert property (
        id_check && medium_cylinder != id_compare_buffer
        |=> result_status_two[4] && result_status_one[2]) else $error("mismatch not set");
    bad_track_a: assert property (
        id_check && medium_cylinder != id_compare_buffer && medium_cylinder == 8'hFF
        |=> result_status_two[1]) else $error("bad track not set");
    protect_set_a: assert property (
        (ev_write_cmd && write_protect) [*3] |=> result_status_one[1])
        else $error("protect flag not set");
    status_read_a: assert property (
        (!port_select_line && !host_fetch_strobe_n && host_store_strobe_n) [*4]
        |-> bus_data_oe) else $error("status read not driven");
    store_quiet_a: assert property (
        (!host_store_strobe_n && host_fetch_strobe_n) [*4] |-> !bus_data_oe)
        else $error("bus driven on store");
endmodule : frs_port_asserts

bind frs_port frs_port_asserts u_chk (
    .clk(clk), .rst_n(rst_n), .port_select_line(port_select_line),
    .host_fetch_strobe_n(host_fetch_strobe_n), .host_store_strobe_n(host_store_strobe_n),
    .bus_data_oe(bus_data_oe), .write_protect(write_protect), .side_choice(side_choice),
    .unit_bit_hi(unit_bit_hi), .unit_bit_lo(unit_bit_lo),
    .ev_past_last_sector(ev_past_last_sector), .ev_id_crc(ev_id_crc),
    .ev_data_mark_absent(ev_data_mark_absent), .ev_write_cmd(ev_write_cmd),
    .id_check(id_check), .medium_cylinder(medium_cylinder),
    .id_compare_buffer(id_compare_buffer), .result_status_one(result_status_one),
    .result_status_two(result_status_two), .result_status_three(result_status_three));
`default_nettype wire

/* File: verif/frs_host_model.sv */
`default_nettype none
module frs_host_model (
    input  wire logic       clk,          // clock
    input  wire logic [7:0] bus_data_out, // device byte
    input  wire logic       bus_data_oe,  // device drives bus
    output logic            sel,          // port select
    output logic            fetch_n,      // read strobe
    output logic            store_n,      // write strobe
    output logic      [7:0] bus_level     // resolved bus
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       hen;
    logic [7:0] hval;

    // released bus shows inverse of last host byte
    assign bus_level = bus_data_oe ? bus_data_out : (hen ? hval : ~hval);

    initial begin
        {sel, fetch_n, store_n, hen} = 4'h6;
        hval = 8'h00;
    end

    // one strobe at a time unless a test asks otherwise
    task automatic access(input logic s, input logic f, input logic w,
                          input logic [7:0] d, output logic [8:0] q);
        @(posedge clk);
        sel     <= s;
        fetch_n <= f;
        store_n <= w;
        hval    <= d;
        hen     <= !w;
        repeat (5) @(posedge clk);
        q = {bus_data_oe, bus_data_out};
        fetch_n <= 1'b1;
        store_n <= 1'b1;
        repeat (3) @(posedge clk);
        hen <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : access
endmodule : frs_host_model
`default_nettype wire

/* File: verif/frs_port_tb_top.sv */
`default_nettype none
module frs_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk, rst_n, sel, fetch_n, store_n, oe, wp, tz, side, uhi, ulo;
    logic       clr, wcmd, idc, txv, txr, rxv, rxr, rxs, rxo;
    logic [7:0] bdi, bdo, ms, medc, idb, txd, rxd, rs1, rs2, rs3;
    logic [9:0] ev;
    logic [1:0] txs;
    logic [8:0] q;
    int         errors, samples_checked, ovf;
    localparam logic [15:0] EV_EXP [10] = '{16'h8000, 16'h2000, 16'h2020, 16'h1000,
        16'h0400, 16'h0100, 16'h0101, 16'h0040, 16'h0008, 16'h0004};
    localparam logic [8:0] SRC_EXP [4] = '{9'h100, 9'h102, 9'h100, 9'h17D};

    frs_port #(.RX_DEPTH(4)) dut (
        .clk(clk), .rst_n(rst_n), .port_select_line(sel),
        .host_fetch_strobe_n(fetch_n), .host_store_strobe_n(store_n),
        .bus_data_in(bdi), .bus_data_out(bdo), .bus_data_oe(oe),
        .write_protect(wp), .track_zero(tz), .main_status(ms),
        .side_choice(side), .unit_bit_hi(uhi), .unit_bit_lo(ulo),
        .result_clear(clr), .ev_past_last_sector(ev[0]), .ev_id_crc(ev[1]),
        .ev_payload_crc(ev[2]), .ev_host_late(ev[3]), .ev_sector_absent(ev[4]),
        .ev_write_cmd(wcmd), .ev_id_mark_absent(ev[5]), .ev_data_mark_absent(ev[6]),
        .ev_deleted_seen(ev[7]), .ev_scan_match(ev[8]), .ev_scan_miss(ev[9]),
        .id_check(idc), .medium_cylinder(medc), .id_compare_buffer(idb),
        .tx_data(txd), .tx_source(txs), .tx_valid(txv), .tx_ready(txr),
        .rx_data(rxd), .rx_valid(rxv), .rx_ready(rxr), .rx_space(rxs),
        .rx_overflow(rxo), .result_status_one(rs1), .result_status_two(rs2),
        .result_status_three(rs3));

    frs_host_model host (
        .clk(clk), .bus_data_out(bdo), .bus_data_oe(oe), .sel(sel),
        .fetch_n(fetch_n), .store_n(store_n), .bus_level(bdi));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (rxo === 1'b1) begin
            ovf <= ovf + 1;
        end
    end

    task automatic cmp(input string what, input logic [8:0] exp, input logic [8:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    task automatic flags(input logic [9:0] e, input logic c, input logic [7:0] m,
                         input logic [7:0] b, input logic [15:0] exp);
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        {clr, ev, idc, medc, idb} <= {1'b0, e, c, m, b};
        @(posedge clk);
        {ev, idc} <= '0;
        @(negedge clk);
        cmp("rs1", {1'b0, exp[15:8]}, {1'b0, rs1});
        cmp("rs2", {1'b0, exp[7:0]}, {1'b0, rs2});
    endtask : flags

    task automatic load(input logic [1:0] s, input logic [7:0] d);
        @(posedge clk);
        {txs, txd, txv} <= {s, d, 1'b1};
        @(posedge clk);
        txv <= 1'b0;
    endtask : load

    task automatic results();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    initial begin
        {errors, samples_checked, ovf} = '0;
        {rst_n, wp, tz, side, uhi, ulo, clr, wcmd, idc, txv, rxr} = '0;
        {ms, medc, idb, txd, txs, ev} = '0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        cmp("reset rs3", 9'h120, {txr, rs3});
        cmp("reset rs1", 9'h000, {rxv, rs1});
        @(posedge clk);
        ms <= 8'hC0;
        host.access(1'b0, 1'b0, 1'b1, 8'h00, q);
        cmp("status", 9'h1C0, q);
        load(2'd0, 8'h3C);
        host.access(1'b1, 1'b0, 1'b1, 8'h00, q);
        cmp("data read", 9'h13C, q);
        cmp("tx ready", 9'h001, {8'h00, txr});
        for (int i = 0; i < 3; i++) begin
            flags(10'(1) << i, 1'b0, 8'h00, 8'h00, EV_EXP[i]);
        end
        for (int i = 3; i < 7; i++) begin
            flags(10'(1) << i, 1'b0, 8'h00, 8'h00, EV_EXP[i]);
        end
        for (int i = 7; i < 10; i++) begin
            flags(10'(1) << i, 1'b0, 8'h00, 8'h00, EV_EXP[i]);
        end
        flags('0, 1'b1, 8'h05, 8'h06, 16'h0410);
        flags('0, 1'b1, 8'hFF, 8'h06, 16'h0412);
        flags('0, 1'b1, 8'hFF, 8'hFF, 16'h0000);
        @(posedge clk);
        {wcmd, wp, tz, side, ulo} <= 5'h1F;
        repeat (5) @(posedge clk);
        @(negedge clk);
        cmp("rs1 protect", 9'h002, {1'b0, rs1});
        cmp("rs3", 9'h07D, {1'b0, rs3});
        for (int s = 1; s < 4; s++) begin
            load(2'(s), 8'h00);
            host.access(1'b1, 1'b0, 1'b1, 8'h00, q);
            cmp("source", SRC_EXP[s], q);
        end
        for (int i = 0; i < 5; i++) begin
            host.access(1'b1, 1'b1, 1'b0, 8'h10 + 8'(i), q);
        end
        cmp("overflow", 9'h001, {rxs, 8'(ovf)});
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            cmp("rx byte", {1'b1, 8'h10 + 8'(i)}, {rxv, rxd});
            @(posedge clk);
            rxr <= 1'b1;
            @(posedge clk);
            rxr <= 1'b0;
        end
        @(negedge clk);
        cmp("rx empty", 9'h001, {rxv, 7'h00, rxs});
        host.access(1'b0, 1'b1, 1'b0, 8'h55, q);
        cmp("sel low store", 9'h000, {q[8], 8'h00});
        host.access(1'b1, 1'b0, 1'b0, 8'h66, q);
        cmp("both strobes", 9'h000, {q[8], 8'h00});
        cmp("no push", 9'h000, {rxv, 8'h00});
        @(posedge clk);
        {uhi, ulo} <= 2'h2;
        repeat (2) @(posedge clk);
        @(negedge clk);
        cmp("rs3 unit", 9'h07E, {1'b0, rs3});
        results();
    end

    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        results();
    end
endmodule : frs_port_tb_top
`default_nettype wire
